// *** cgsc_osc_model.sv ***
`timescale 1ns/1ns
module cgsc_osc_model
   import cgsc_pkg::*;
(
   input  cgsc_osc_set_t osc_en_out,
   output logic          fast_internal_clk,
   output logic          low_speed_crystal_clk,
   output logic          high_speed_osc_clk,
   output logic          external_clock_input
);
   // ***********************************
   // resonators stand low while disabled
   // ***********************************
   // periods slower than half the core clock; no toggle lands on a rising core edge
   initial begin
      fast_internal_clk = 1'b0;
      forever #300 fast_internal_clk = osc_en_out.fast_en & ~fast_internal_clk;
   end
   initial begin
      low_speed_crystal_clk = 1'b0;
      forever #200 low_speed_crystal_clk = osc_en_out.xtal_en & ~low_speed_crystal_clk;
   end
   initial begin
      high_speed_osc_clk = 1'b0;
      forever #300 high_speed_osc_clk = osc_en_out.hs_en & ~high_speed_osc_clk;
   end
   // external source is stable before anyone enables it
   initial begin
      external_clock_input = 1'b0;
      forever #400 external_clock_input = ~external_clock_input;
   end
endmodule // cgsc_osc_model

// *** cgsc_osc_start_ctrl.sv ***
// Design decisions made here: the address map and the AHB-Lite register port.
`timescale 1ns/1ns
module cgsc_osc_start_ctrl
   import cgsc_pkg::*;
(
   input  logic          core_clk,
   input  logic          reset,
   input  logic          hsel,
   input  logic [31:0]   haddr,
   input  logic [1:0]    htrans,
   input  logic          hwrite,
   input  logic [2:0]    hsize,
   input  logic [31:0]   hwdata,
   input  logic          hready,
   output logic [31:0]   hrdata,
   output logic          hreadyout,
   output logic          hresp,
   input  logic          fast_internal_clk,
   input  logic          low_speed_crystal_clk,
   input  logic          high_speed_osc_clk,
   input  logic          external_clock_input,
   output cgsc_osc_set_t osc_en_out,
   output logic          crystal_high_gain,
   output logic [5:0]    fast_internal_trim,
   output cgsc_hs_type_t high_speed_type,
   output logic          system_clk,
   output logic          crystal_clk_gated,
   output logic          high_speed_clk_gated,
   output logic          external_clk_gated,
   output logic          clock_out_ch0,
   output logic          clock_out_ch1,
   output logic          irq
);

   // ***************************************************************
   // declarations
   // ***************************************************************
   cgsc_osc_set_t  osc_ctrl_reg;
   cgsc_xtal_cfg_t xtal_cfg_reg;
   cgsc_hs_cfg_t   hs_cfg_reg;
   logic [5:0]     trim_reg;
   logic [15:0]    prot_key_reg;
   logic [IRQ_W-1:0] irq_stat_reg;
   logic [IRQ_W-1:0] irq_stat_next;
   logic [IRQ_W-1:0] irq_en_reg;
   logic [31:0]    hrdata_reg;
   logic [7:0]     addr_reg;
   logic           wr_pend_reg;
   logic           xtal_prev_reg;
   logic [BOOST_CNT_W-1:0] boost_cnt_reg;
   logic [BOOST_CNT_W-1:0] boost_cnt_next;
   logic           high_gain_reg;
   logic           system_clk_reg;
   logic           xtal_gated_reg;
   logic           hs_gated_reg;
   logic           ext_gated_reg;

   logic [3:0]     osc_raw;
   logic [3:0]     osc_level;
   logic [3:0]     osc_tick;
   logic [IRQ_W-1:0] osc_ready;
   logic [IRQ_W-1:0] wait_done;
   logic [IRQ_W-1:0][WAIT_CNT_W-1:0] wait_len;

   logic           addr_phase;
   logic           unlocked;
   logic           wr_osc;
   logic           wr_xtal_try;
   logic           wr_hs_try;
   logic           wr_trim_try;
   logic           wr_xtal;
   logic           wr_hs;
   logic           wr_trim;
   logic           wr_irq_clr;
   logic           wr_irq_en;
   logic           wr_prot;
   logic           xtal_start;
   logic [31:0]    rd_word;
   cgsc_xtal_cfg_t xtal_wr;
   cgsc_hs_cfg_t   hs_wr;
   logic           hs_type_ok;

   localparam logic [BOOST_CNT_W-1:0] BOOST_LOAD = BOOST_CYCLES[BOOST_CNT_W-1:0];

   if (BOOST_CYCLES >= (1 << BOOST_CNT_W)) begin : g_bad_boost
      $error("cgsc_osc_start_ctrl: boost period exceeds counter");
   end

   function automatic logic is_word(input logic [7:0] a, input logic [7:0] off);
      return a == off;
   endfunction

   // ***************************************************************
   // ahb-lite slave: zero wait states, always okay
   // ***************************************************************
   assign addr_phase  = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == 2'h3);
   assign unlocked    = (prot_key_reg == PROT_KEY);
   assign wr_osc      = wr_pend_reg && is_word(addr_reg, ADDR_OSC_CTRL);
   assign wr_xtal_try = wr_pend_reg && is_word(addr_reg, ADDR_XTAL_CFG);
   assign wr_hs_try   = wr_pend_reg && is_word(addr_reg, ADDR_HS_CFG);
   assign wr_trim_try = wr_pend_reg && is_word(addr_reg, ADDR_TRIM);
   assign wr_xtal     = wr_xtal_try && unlocked;
   assign wr_hs       = wr_hs_try && unlocked;
   assign wr_trim     = wr_trim_try && unlocked;
   assign wr_irq_clr  = wr_pend_reg && is_word(addr_reg, ADDR_IRQ_CLR);
   assign wr_irq_en   = wr_pend_reg && is_word(addr_reg, ADDR_IRQ_EN);
   assign wr_prot     = wr_pend_reg && is_word(addr_reg, ADDR_PROT);

   assign xtal_wr    = cgsc_xtal_cfg_t'(hwdata);
   assign hs_wr      = cgsc_hs_cfg_t'(hwdata);
   // the unused type code is refused so the selection stays legal
   assign hs_type_ok = hs_wr.hs_type inside {HS_XTAL, HS_CR, HS_INT};

   assign rd_word =
      is_word(haddr[7:0], ADDR_OSC_CTRL) ? {28'h0000000, osc_ctrl_reg} :
      is_word(haddr[7:0], ADDR_XTAL_CFG) ? xtal_cfg_reg :
      is_word(haddr[7:0], ADDR_HS_CFG)   ? hs_cfg_reg :
      is_word(haddr[7:0], ADDR_TRIM)     ? {26'h0, trim_reg} :
      is_word(haddr[7:0], ADDR_IRQ_STAT) ? {29'h0, irq_stat_reg} :
      is_word(haddr[7:0], ADDR_IRQ_EN)   ? {29'h0, irq_en_reg} :
      is_word(haddr[7:0], ADDR_PROT)     ? {16'h0000, prot_key_reg} :
      is_word(haddr[7:0], ADDR_CLK_STAT) ? {28'h0000000, high_gain_reg, osc_ready} :
      32'h00000000;

   always_ff @(posedge core_clk) begin
      if (reset) begin
         addr_reg    <= 8'h00;
         wr_pend_reg <= 1'b0;
         hrdata_reg  <= 32'h00000000;
      end else begin
         wr_pend_reg <= addr_phase && hwrite;
         if (addr_phase) begin
            addr_reg <= haddr[7:0];
         end
         if (addr_phase && !hwrite) begin
            hrdata_reg <= rd_word;
         end
      end
   end

   assign hrdata    = hrdata_reg;
   assign hreadyout = 1'b1;
   assign hresp     = HRESP_OKAY;

   // ***************************************************************
   // control registers
   // ***************************************************************
   always_ff @(posedge core_clk) begin
      if (reset) begin
         osc_ctrl_reg <= OSC_CTRL_RST;
         xtal_cfg_reg <= '0;
         hs_cfg_reg   <= '0;
         trim_reg     <= TRIM_RST;
         prot_key_reg <= 16'h0000;
         irq_en_reg   <= '0;
      end else begin
         if (wr_osc) begin
            osc_ctrl_reg <= hwdata[3:0];
         end
         if (wr_xtal) begin
            xtal_cfg_reg <= '{rsvd: '0, boost_en: xtal_wr.boost_en, wait_sel: xtal_wr.wait_sel};
         end
         if (wr_hs) begin
            hs_cfg_reg.wait_sel <= hs_wr.wait_sel;
            if (hs_type_ok) begin
               hs_cfg_reg.hs_type <= hs_wr.hs_type;
            end
         end
         if (wr_trim) begin
            trim_reg <= hwdata[5:0];
         end
         if (wr_prot) begin
            prot_key_reg <= hwdata[15:0];
         end
         if (wr_irq_en) begin
            irq_en_reg <= hwdata[IRQ_W-1:0];
         end
      end
   end

   // ***************************************************************
   // oscillator sampling and stabilization wait
   // ***************************************************************
   assign osc_raw = {external_clock_input, high_speed_osc_clk, low_speed_crystal_clk, fast_internal_clk};
   assign wait_len[0] = FAST_WAIT_CYCLES;
   assign wait_len[1] = XTAL_WAIT_TBL[xtal_cfg_reg.wait_sel];
   assign wait_len[2] = HS_WAIT_TBL[hs_cfg_reg.wait_sel];

   for (genvar i = 0; i < 4; i++) begin : g_sync
      cgsc_osc_sync u_sync (
         .core_clk  (core_clk),
         .reset     (reset),
         .osc_in    (osc_raw[i]),
         .osc_level (osc_level[i]),
         .osc_tick  (osc_tick[i])
      );
   end

   for (genvar i = 0; i < IRQ_W; i++) begin : g_wait
      cgsc_stab_wait #(.CNT_W(WAIT_CNT_W)) u_wait (
         .core_clk  (core_clk),
         .reset     (reset),
         .osc_en    (osc_ctrl_reg[i]),
         .osc_tick  (osc_tick[i]),
         .wait_len  (wait_len[i]),
         .osc_ready (osc_ready[i]),
         .wait_done (wait_done[i])
      );
   end

   // ***************************************************************
   // crystal startup boost
   // ***************************************************************
   assign xtal_start     = osc_ctrl_reg.xtal_en && !xtal_prev_reg;
   assign boost_cnt_next = !osc_ctrl_reg.xtal_en ? '0 :
                           (xtal_start && xtal_cfg_reg.boost_en) ? BOOST_LOAD :
                           (boost_cnt_reg != '0) ? boost_cnt_reg - 1'b1 : '0;

   always_ff @(posedge core_clk) begin
      if (reset) begin
         xtal_prev_reg <= 1'b0;
         boost_cnt_reg <= '0;
         high_gain_reg <= 1'b0;
      end else begin
         xtal_prev_reg <= osc_ctrl_reg.xtal_en;
         boost_cnt_reg <= boost_cnt_next;
         high_gain_reg <= (boost_cnt_next != '0);
      end
   end

   // ***************************************************************
   // interrupts and clock gates
   // ***************************************************************
   // a completion in the clearing cycle survives the clear
   assign irq_stat_next = (irq_stat_reg & ~(wr_irq_clr ? hwdata[IRQ_W-1:0] : '0)) | wait_done;

   always_ff @(posedge core_clk) begin
      if (reset) begin
         irq_stat_reg   <= '0;
         system_clk_reg <= 1'b0;
         xtal_gated_reg <= 1'b0;
         hs_gated_reg   <= 1'b0;
         ext_gated_reg  <= 1'b0;
      end else begin
         irq_stat_reg   <= irq_stat_next;
         system_clk_reg <= osc_level[0] && osc_ready[0];
         xtal_gated_reg <= osc_level[1] && osc_ready[1];
         hs_gated_reg   <= osc_level[2] && osc_ready[2];
         // no wait counter here: software must present a stable clock first
         ext_gated_reg  <= osc_level[3] && osc_ctrl_reg.ext_en;
      end
   end

   assign irq                  = |(irq_stat_reg & irq_en_reg);
   assign osc_en_out           = osc_ctrl_reg;
   assign crystal_high_gain    = high_gain_reg;
   assign fast_internal_trim   = trim_reg;
   assign high_speed_type      = hs_cfg_reg.hs_type;
   assign system_clk           = system_clk_reg;
   assign crystal_clk_gated    = xtal_gated_reg;
   assign high_speed_clk_gated = hs_gated_reg;
   assign external_clk_gated   = ext_gated_reg;
   // output dividers live elsewhere; these pins hold their idle low level
   assign clock_out_ch0        = 1'b0;
   assign clock_out_ch1        = 1'b0;

   // ***************************************************************
   // assertions
   // ***************************************************************
   logic [7:0] fast_ticks_reg;

   always_ff @(posedge core_clk) begin
      if (reset || !osc_ctrl_reg.fast_en) begin
         fast_ticks_reg <= 8'h00;
      end else if (!osc_ready[0] && osc_tick[0]) begin
         fast_ticks_reg <= fast_ticks_reg + 8'h01;
      end
   end

   property p_boot_fast;
      @(posedge core_clk) $fell(reset) |-> osc_en_out.fast_en && !crystal_high_gain;
   endproperty
   a_boot_fast: assert property (p_boot_fast) else $error("fast oscillator not enabled at boot");

   property p_gate_closed;
      @(posedge core_clk) disable iff (reset) !osc_ready[1] |=> !crystal_clk_gated;
   endproperty
   a_gate_closed: assert property (p_gate_closed) else $error("crystal clock leaked before ready");

   property p_fast_count;
      @(posedge core_clk) disable iff (reset) $rose(osc_ready[0]) |-> fast_ticks_reg == 8'h10;
   endproperty
   a_fast_count: assert property (p_fast_count) else $error("fast wait not 16 ticks");

   property p_done_sets_flag;
      @(posedge core_clk) disable iff (reset) wait_done[0] |=> irq_stat_reg[0] && osc_ready[0];
   endproperty
   a_done_sets_flag: assert property (p_done_sets_flag) else $error("ready flag not set on completion");

   property p_restart;
      @(posedge core_clk) disable iff (reset) $rose(osc_ctrl_reg.fast_en) |-> !osc_ready[0] [*2];
   endproperty
   a_restart: assert property (p_restart) else $error("start skipped the wait");

   property p_boost;
      @(posedge core_clk) disable iff (reset)
         ($rose(osc_ctrl_reg.xtal_en) && xtal_cfg_reg.boost_en) |=>
            crystal_high_gain ##[1:1000] !crystal_high_gain;
   endproperty
   a_boost: assert property (p_boost) else $error("boost period wrong");

   property p_clear;
      @(posedge core_clk) disable iff (reset)
         (wr_irq_clr && hwdata[0] && !wait_done[0]) |=> !irq_stat_reg[0];
   endproperty
   a_clear: assert property (p_clear) else $error("ready flag not cleared");

   property p_locked;
      @(posedge core_clk) disable iff (reset) (wr_trim_try && !unlocked) |=> $stable(trim_reg);
   endproperty
   a_locked: assert property (p_locked) else $error("trim written while locked");

   property p_start;
      @(posedge core_clk) disable iff (reset) (wr_osc && hwdata[0]) |=> osc_en_out.fast_en;
   endproperty
   a_start: assert property (p_start) else $error("fast enable write lost");

   property p_fout_low;
      @(posedge core_clk) disable iff (reset) !clock_out_ch0 && !clock_out_ch1;
   endproperty
   a_fout_low: assert property (p_fout_low) else $error("clock output not low");

   property p_hs_type;
      @(posedge core_clk) disable iff (reset) high_speed_type != 2'h3;
   endproperty
   a_hs_type: assert property (p_hs_type) else $error("illegal oscillator type");

   property p_irq;
      @(posedge core_clk) disable iff (reset) (irq_stat_reg[0] && irq_en_reg[0]) |-> irq;
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt missing");

   property p_stop;
      @(posedge core_clk) disable iff (reset)
         $fell(osc_ctrl_reg.hs_en) |=> !osc_ready[2] ##1 !high_speed_clk_gated;
   endproperty
   a_stop: assert property (p_stop) else $error("clock kept after disable");

   c_fast_ready: cover property (@(posedge core_clk) disable iff (reset) $rose(osc_ready[0]));
   c_irq:        cover property (@(posedge core_clk) disable iff (reset) $rose(irq));
   c_boost:      cover property (@(posedge core_clk) disable iff (reset) $fell(crystal_high_gain));
   c_unlock:     cover property (@(posedge core_clk) disable iff (reset) wr_trim);

endmodule // cgsc_osc_start_ctrl

// *** cgsc_osc_sync.sv ***
`timescale 1ns/1ns
module cgsc_osc_sync
   import cgsc_pkg::*;
(
   input  logic core_clk,
   input  logic reset,
   input  logic osc_in,
   output logic osc_level,
   output logic osc_tick
);

   logic meta_reg;
   logic sync_reg;
   logic prev_reg;

   // oscillator edges are only seen below half the core rate
   always_ff @(posedge core_clk) begin
      if (reset) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         prev_reg <= 1'b0;
      end else begin
         meta_reg <= osc_in;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end

   assign osc_level = sync_reg;
   assign osc_tick  = sync_reg & ~prev_reg;

endmodule // cgsc_osc_sync

// *** cgsc_pkg.sv ***
package cgsc_pkg;

   // ***************************************************************
   // register map (byte addresses, low address bits)
   // ***************************************************************
   localparam logic [7:0] ADDR_OSC_CTRL = 8'h00;
   localparam logic [7:0] ADDR_XTAL_CFG = 8'h04;
   localparam logic [7:0] ADDR_HS_CFG   = 8'h08;
   localparam logic [7:0] ADDR_TRIM     = 8'h0c;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
   localparam logic [7:0] ADDR_IRQ_CLR  = 8'h14;
   localparam logic [7:0] ADDR_IRQ_EN   = 8'h18;
   localparam logic [7:0] ADDR_PROT     = 8'h1c;
   localparam logic [7:0] ADDR_CLK_STAT = 8'h20;

   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic       HRESP_OKAY    = 1'b0;

   // ***************************************************************
   // field layouts and reset values
   // ***************************************************************
   typedef struct packed {
      logic ext_en;
      logic hs_en;
      logic xtal_en;
      logic fast_en;
   } cgsc_osc_set_t;

   typedef struct packed {
      logic [28:0] rsvd;
      logic        boost_en;
      logic [1:0]  wait_sel;
   } cgsc_xtal_cfg_t;

   typedef enum logic [1:0] {
      HS_XTAL = 2'h0,
      HS_CR   = 2'h1,
      HS_INT  = 2'h2
   } cgsc_hs_type_t;

   typedef struct packed {
      logic [24:0]   rsvd_hi;
      logic [2:0]    wait_sel;
      logic [1:0]    rsvd_lo;
      cgsc_hs_type_t hs_type;
   } cgsc_hs_cfg_t;

   typedef enum logic [2:0] {
      ST_OFF  = 3'h1,
      ST_WAIT = 3'h2,
      ST_RUN  = 3'h4
   } cgsc_wait_state_t;

   localparam cgsc_osc_set_t OSC_CTRL_RST = 4'h1;
   localparam logic [5:0]    TRIM_RST     = 6'h20;
   localparam logic [15:0]   PROT_KEY     = 16'h0096;
   localparam int            IRQ_W        = 3;
   localparam int            WAIT_CNT_W   = 16;

   // ***************************************************************
   // timing
   // ***************************************************************
   localparam logic [15:0] FAST_WAIT_CYCLES = 16'h0010;
   localparam logic [3:0][15:0] XTAL_WAIT_TBL = {16'h1000, 16'h0400, 16'h0200, 16'h0080};
   localparam logic [7:0][15:0] HS_WAIT_TBL =
      {16'h1000, 16'h0400, 16'h0200, 16'h0100, 16'h0080, 16'h0040, 16'h0010, 16'h0004};
   localparam int CLK_PERIOD_NS = 100;
   localparam int BOOST_TIME_NS = 100000;
   localparam int BOOST_CYCLES  = (BOOST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BOOST_CNT_W   = 11;

endpackage

// *** cgsc_stab_wait.sv ***
`timescale 1ns/1ns
module cgsc_stab_wait
   import cgsc_pkg::*;
#(
   parameter int CNT_W = WAIT_CNT_W
)
(
   input  logic             core_clk,
   input  logic             reset,
   input  logic             osc_en,
   input  logic             osc_tick,
   input  logic [CNT_W-1:0] wait_len,
   output logic             osc_ready,
   output logic             wait_done
);

   cgsc_wait_state_t state_reg;
   cgsc_wait_state_t state_next;
   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] cnt_next;
   logic [CNT_W-1:0] cnt_inc;
   logic             hit;

   if (CNT_W < 2) begin : g_bad_width
      $error("cgsc_stab_wait: CNT_W too small");
   end

   assign cnt_inc   = cnt_reg + 1'b1;
   assign hit       = osc_tick && (cnt_inc >= wait_len);
   assign wait_done = (state_reg == ST_WAIT) && osc_en && hit;
   assign osc_ready = (state_reg == ST_RUN);

   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      case (state_reg)
         ST_OFF: begin
            cnt_next = '0;
            if (osc_en) begin
               state_next = ST_WAIT;
               cnt_next   = osc_tick ? {{(CNT_W-1){1'b0}}, 1'b1} : '0;
            end
         end
         ST_WAIT: begin
            if (!osc_en) begin
               state_next = ST_OFF;
               cnt_next   = '0;
            end else if (hit) begin
               state_next = ST_RUN;
            end else if (osc_tick) begin
               cnt_next = cnt_inc;
            end
         end
         ST_RUN: begin
            if (!osc_en) begin
               state_next = ST_OFF;
               cnt_next   = '0;
            end
         end
         default: begin
            state_next = ST_OFF;
            cnt_next   = '0;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         state_reg <= ST_OFF;
         cnt_reg   <= '0;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
      end
   end

endmodule // cgsc_stab_wait

// *** oscillator_start_stabilization_ctrl_test.sv ***
`timescale 1ns/1ns
module oscillator_start_stabilization_ctrl_test;
   import cgsc_pkg::*;
   logic          core_clk, reset, hsel, hwrite, hready, hreadyout, hresp, irq, crystal_high_gain, system_clk;
   logic          crystal_clk_gated, high_speed_clk_gated, external_clk_gated, clock_out_ch0, clock_out_ch1;
   logic          fast_internal_clk, low_speed_crystal_clk, high_speed_osc_clk, external_clock_input;
   logic [31:0]   haddr, hwdata, hrdata, rd;
   logic [1:0]    htrans;
   logic [2:0]    hsize;
   logic [5:0]    fast_internal_trim;
   cgsc_osc_set_t osc_en_out;
   cgsc_hs_type_t high_speed_type;
   int            err_count = 0, checks_done = 0, cyc = 0, n, t0, hi;
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin err_count++; $display("BAD %s exp %h got %h", nm, e, g); end end

   assign hready = hreadyout;
   cgsc_osc_start_ctrl u_cgsc_osc_start_ctrl (
      .core_clk (core_clk), .reset (reset), .hsel (hsel), .haddr (haddr), .htrans (htrans), .hwrite (hwrite),
      .hsize (hsize), .hwdata (hwdata), .hready (hready), .hrdata (hrdata), .hreadyout (hreadyout), .hresp (hresp),
      .fast_internal_clk (fast_internal_clk), .low_speed_crystal_clk (low_speed_crystal_clk),
      .high_speed_osc_clk (high_speed_osc_clk), .external_clock_input (external_clock_input),
      .osc_en_out (osc_en_out), .crystal_high_gain (crystal_high_gain), .fast_internal_trim (fast_internal_trim),
      .high_speed_type (high_speed_type), .system_clk (system_clk), .crystal_clk_gated (crystal_clk_gated),
      .high_speed_clk_gated (high_speed_clk_gated), .external_clk_gated (external_clk_gated),
      .clock_out_ch0 (clock_out_ch0), .clock_out_ch1 (clock_out_ch1), .irq (irq)
   );
   cgsc_osc_model u_cgsc_osc_model (
      .osc_en_out (osc_en_out), .fast_internal_clk (fast_internal_clk),
      .low_speed_crystal_clk (low_speed_crystal_clk), .high_speed_osc_clk (high_speed_osc_clk),
      .external_clock_input (external_clock_input)
   );

   // ***********************************
   // clock, bus access and verdict
   // ***********************************
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   always @(posedge core_clk) cyc <= cyc + 1;

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      haddr <= {24'h0, a};
      do @(posedge core_clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge core_clk); while (hready !== 1'b1);
      rd = hrdata;
      // let the write land before callers look at outputs
      #1;
   endtask

   // n returns the cycles spent until the masked value matched
   task automatic poll(input logic [7:0] a, input logic [31:0] m);
      n = cyc;
      do bus(1'b0, a, 32'h0); while ((rd & m) !== m && cyc - n < 6000);
      n = cyc - n;
   endtask

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial begin
      #1000000;
      err_count++;
      end_of_test;
   end

   // ***********************************
   // tests
   // ***********************************
   initial begin
      reset = 1'b1; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0;
      repeat (6) @(posedge core_clk);
      reset <= 1'b0;
      @(posedge core_clk);
      `CHK("osc_en", 4'h1, osc_en_out)
      `CHK("trim", 6'h20, fast_internal_trim)
      `CHK("clock_out_ch0", 1'b0, clock_out_ch0)
      `CHK("clock_out_ch1", 1'b0, clock_out_ch1)
      `CHK("hresp", HRESP_OKAY, hresp)
      `CHK("hreadyout", 1'b1, hreadyout)
      repeat (60) begin
         @(posedge core_clk);
         `CHK("gate", 1'b0, system_clk)
      end
      poll(ADDR_CLK_STAT, 32'h1);
      `CHK("fast wait", 1'b1, (n + 60) inside {[84:112]})
      hi = 0;
      repeat (12) begin
         @(posedge core_clk);
         hi += system_clk;
      end
      `CHK("sys run", 1'b1, hi > 0)
      $display("test boot done");
      bus(1'b1, ADDR_OSC_CTRL, 32'h0);
      // ready drops one edge after the enable does
      @(posedge core_clk);
      bus(1'b0, ADDR_CLK_STAT, 32'h0);
      `CHK("stop", 1'b0, rd[0])
      bus(1'b1, ADDR_OSC_CTRL, 32'h1);
      bus(1'b0, ADDR_CLK_STAT, 32'h0);
      `CHK("rewait", 1'b0, rd[0])
      bus(1'b0, ADDR_IRQ_STAT, 32'h0);
      `CHK("sticky", 1'b1, rd[0])
      `CHK("irq off", 1'b0, irq)
      poll(ADDR_CLK_STAT, 32'h1);
      `CHK("restart", 1'b1, n inside {[84:112]})
      bus(1'b1, ADDR_IRQ_EN, 32'h1);
      `CHK("irq on", 1'b1, irq)
      bus(1'b1, ADDR_IRQ_CLR, 32'h1);
      `CHK("irq clr", 1'b0, irq)
      bus(1'b0, ADDR_IRQ_STAT, 32'h0);
      `CHK("flag clr", 32'h0, rd)
      $display("test restart done");
      bus(1'b1, ADDR_OSC_CTRL, 32'h0);
      bus(1'b1, ADDR_TRIM, 32'h15);
      bus(1'b0, ADDR_TRIM, 32'h0);
      `CHK("locked", 32'h20, rd)
      bus(1'b1, ADDR_PROT, {16'h0, PROT_KEY});
      bus(1'b1, ADDR_TRIM, 32'h15);
      `CHK("trim", 6'h15, fast_internal_trim)
      bus(1'b1, ADDR_PROT, 32'h0);
      bus(1'b1, ADDR_TRIM, 32'h3);
      bus(1'b0, ADDR_TRIM, 32'h0);
      `CHK("relock", 32'h15, rd)
      bus(1'b0, 8'h40, 32'h0);
      `CHK("unmapped", 32'h0, rd)
      $display("test protect done");
      bus(1'b1, ADDR_PROT, {16'h0, PROT_KEY});
      for (int t = 0; t < 4; t++) begin
         bus(1'b1, ADDR_HS_CFG, 32'h60 | t);
         `CHK("hs type", (t < 3) ? t[1:0] : 2'h2, high_speed_type)
      end
      bus(1'b1, ADDR_HS_CFG, 32'h1);
      bus(1'b1, ADDR_XTAL_CFG, 32'h4);
      bus(1'b1, ADDR_PROT, 32'h0);
      bus(1'b1, ADDR_OSC_CTRL, 32'h7);
      t0 = cyc;
      poll(ADDR_CLK_STAT, 32'h4);
      `CHK("hs wait", 1'b1, n inside {[20:40]})
      `CHK("xtal gate", 1'b0, crystal_clk_gated)
      `CHK("boost", 1'b1, crystal_high_gain)
      poll(ADDR_CLK_STAT, 32'h2);
      `CHK("xtal wait", 1'b1, (cyc - t0) inside {[500:540]})
      `CHK("boost", 1'b1, crystal_high_gain)
      bus(1'b0, ADDR_IRQ_STAT, 32'h0);
      `CHK("flags", 32'h7, rd)
      `CHK("irq", 1'b1, irq)
      n = 0;
      hi = 0;
      repeat (12) begin
         @(posedge core_clk);
         n += crystal_clk_gated;
         hi += high_speed_clk_gated;
      end
      `CHK("xtal clk", 1'b1, n > 0)
      `CHK("hs clk", 1'b1, hi > 0)
      while (cyc - t0 < 1100) @(posedge core_clk);
      `CHK("boost end", 1'b0, crystal_high_gain)
      bus(1'b1, ADDR_OSC_CTRL, 32'hb);
      repeat (2) @(posedge core_clk);
      n = 0;
      hi = 0;
      repeat (20) begin
         @(posedge core_clk);
         n += external_clk_gated;
         hi += high_speed_clk_gated;
      end
      `CHK("ext clk", 1'b1, n > 0)
      `CHK("hs stop", 0, hi)
      $display("test crystal done");
      end_of_test;
   end
endmodule // oscillator_start_stabilization_ctrl_test
